//--- src/fcp_top.sv
// Four-channel PWM with prescaler, scalers, pair joining and port pin sharing.
// Operation
// - Four 8-bit channels, or two 16-bit, or one 16-bit plus two 8-bit.
// - Each channel has own period, duty and counter making a continuous waveform.
// - Duty settings reach every ratio from fully off to fully on.
// - Outputs are left-aligned or center-aligned.
// - Enabled channel takes new period/duty only at rollover, on a counter write or on disable.
// - Disabled channel writes update buffer and active value together.
// - Counter write clears the counter and loads buffered period and duty.
// - Software can read each channel counter.
// - Enabled channel owns its pin, except the low channel of a joined pair; unused pins stay general I/O.
// - Join of pair 2/3: channel 2 high byte, channel 3 clock, pin 2 output.
// - Join of pair 0/1: channel 0 high byte, channel 1 clock, pin 0 output.
// - Clock A is base clock divided by two to the three-bit code.
// - Clock B uses its own three-bit code with the same encoding.
// - Select bit picks A or S0 for channels 0/1, B or S1 for 2/3.
// - Polarity bits act only in left-aligned operation.
// - Polarity 0 starts low, rises at duty; polarity 1 starts high, falls.
// - Left-aligned duty counts low time at polarity 0, high time at 1.
// - S0 is clock A divided by scale 0 plus one, then by two.
// - S1 is clock B divided by scale 1 plus one, then by two.
// - Enable forces pin to output without touching its direction bit.
// - Enabled counter resumes from present count; disable never clears it.
`timescale 1ns/10ps
`include "fcp_params.svh"
module fcp_top (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic [7:0]      rd_data,
  input  wire logic [3:0] port_in,
  output logic [3:0]      port_out,
  output logic [3:0]      port_oe_n
);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] clock_join_reg;
  logic [7:0] clock_sel_polarity_reg;
  logic [3:0] channel_enable_bits;
  logic [7:0] scale_value_0;
  logic [7:0] scale_value_1;
  logic       center_align_sel;
  logic [3:0] port_data;
  logic [3:0] port_dir;
  logic [7:0] per_buf [4];
  logic [7:0] dty_buf [4];
  logic [7:0] cnt_all [4];
  logic [3:0] wave;
  logic [3:0] pwm_drive;
  logic [7:0] rd_mux;

  logic                   tick_a;
  logic                   tick_b;
  logic [`FCP_PRES_W-1:0] pres;
  logic                   tick_s0;
  logic                   tick_s1;
  logic [7:0]             scnt0;
  logic [7:0]             scnt1;
  logic [1:0]             base_tick;
  logic [1:0]             scaled_tick;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clock_join_reg         <= `FCP_RST_ZERO;
      clock_sel_polarity_reg <= `FCP_RST_ZERO;
      channel_enable_bits    <= 4'h0;
      scale_value_0          <= `FCP_RST_ZERO;
      scale_value_1          <= `FCP_RST_ZERO;
      center_align_sel       <= 1'b0;
      port_data              <= 4'h0;
      port_dir               <= 4'h0;
    end else if (wr_en) begin
      unique case (addr)
        `FCP_ADDR_CLK:   clock_join_reg         <= wr_data;
        `FCP_ADDR_POL:   clock_sel_polarity_reg <= wr_data;
        `FCP_ADDR_EN:    channel_enable_bits    <= wr_data[3:0];
        `FCP_ADDR_SCAL0: scale_value_0          <= wr_data;
        `FCP_ADDR_SCAL1: scale_value_1          <= wr_data;
        `FCP_ADDR_CTL:   center_align_sel       <= wr_data[`FCP_CENTER_BIT];
        `FCP_ADDR_PDAT:  port_data              <= wr_data[3:0];
        `FCP_ADDR_PDIR:  port_dir               <= wr_data[3:0];
        default: ;
      endcase
    end
  end

  // Buffers always take the write; reading them returns the last value written.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < 4; k++) begin
        per_buf[k] <= `FCP_RST_PER;
        dty_buf[k] <= `FCP_RST_DTY;
      end
    end else if (wr_en) begin
      for (int k = 0; k < 4; k++) begin
        if (addr == 8'(`FCP_ADDR_PER0 + k)) begin
          per_buf[k] <= wr_data;
        end
        if (addr == 8'(`FCP_ADDR_DTY0 + k)) begin
          dty_buf[k] <= wr_data;
        end
      end
    end
  end

  // ==========================================================================
  // Clock sources
  // ==========================================================================
  fcp_clkgen u_clkgen (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (|channel_enable_bits),
    .code_a   (clock_join_reg[`FCP_PCKA_LSB +: 3]),
    .code_b   (clock_join_reg[`FCP_PCKB_LSB +: 3]),
    .tick_a   (tick_a),
    .tick_b   (tick_b),
    .pres     (pres)
  );

  fcp_scaler u_scaler0 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick_in  (tick_a),
    .load     (wr_en && (addr == `FCP_ADDR_SCAL0)),
    .scale    (wr_en && (addr == `FCP_ADDR_SCAL0) ? wr_data : scale_value_0),
    .tick_out (tick_s0),
    .count    (scnt0)
  );

  fcp_scaler u_scaler1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick_in  (tick_b),
    .load     (wr_en && (addr == `FCP_ADDR_SCAL1)),
    .scale    (wr_en && (addr == `FCP_ADDR_SCAL1) ? wr_data : scale_value_1),
    .tick_out (tick_s1),
    .count    (scnt1)
  );

  assign base_tick   = {tick_b, tick_a};
  assign scaled_tick = {tick_s1, tick_s0};

  // ==========================================================================
  // Counter step shared by 8-bit and joined 16-bit channels
  // ==========================================================================
  // Returns {rollover, count down, next count}.
  function automatic logic [17:0] fcp_step(input logic [15:0] c,
                                           input logic [15:0] p,
                                           input logic        dn,
                                           input logic        ctr);
    logic [15:0] n;
    logic        d;
    logic        r;
    n = c;
    d = dn;
    r = 1'b0;
    if (!ctr) begin
      d = 1'b0;
      if (c >= p) begin
        n = 16'h0000;
        r = 1'b1;
      end else begin
        n = c + 16'h0001;
      end
    end else if (!dn) begin
      if (c >= p) begin
        d = 1'b1;
        n = (c == 16'h0000) ? c : c - 16'h0001;
      end else begin
        n = c + 16'h0001;
      end
    end else begin
      if (c == 16'h0000) begin
        d = 1'b0;
        r = 1'b1;
        n = (p == 16'h0000) ? 16'h0000 : 16'h0001;
      end else begin
        n = c - 16'h0001;
      end
    end
    return {r, d, n};
  endfunction

  // Left-aligned level follows polarity; center-aligned ignores it.
  function automatic logic fcp_level(input logic [15:0] c,
                                     input logic [15:0] d,
                                     input logic        pol,
                                     input logic        ctr);
    if (ctr) begin
      return c < d;
    end
    return pol ? (c < d) : (c >= d);
  endfunction

  // ==========================================================================
  // Channel pairs: high channel 2p, low channel 2p+1
  // ==========================================================================
  for (genvar p = 0; p < 2; p++) begin : g_pair
    localparam int H = 2 * p;
    localparam int L = 2 * p + 1;
    localparam int JB = (p == 0) ? `FCP_JOIN_LO_BIT : `FCP_JOIN_HI_BIT;

    logic              join_on;
    logic [7:0]        cnt     [2];
    logic [7:0]        per_act [2];
    logic [7:0]        dty_act [2];
    fcp_pkg::fcp_dir_e dir     [2];
    logic [1:0]        lvl;
    logic [1:0]        tick;
    logic [1:0]        en;
    logic [17:0]       step8   [2];
    logic [17:0]       step16;
    logic              tick16;
    logic [15:0]       cnt16;
    logic [15:0]       per16;
    logic [15:0]       dty16;

    assign join_on = clock_join_reg[JB];
    assign en      = {channel_enable_bits[L], channel_enable_bits[H]};
    for (genvar k = 0; k < 2; k++) begin : g_tick
      // Each channel runs only while enabled, on the source its select bit picks.
      assign tick[k] = en[k] && (clock_sel_polarity_reg[`FCP_SEL_LSB + H + k]
                                 ? scaled_tick[p] : base_tick[p]);
      assign step8[k] = fcp_step({8'h00, cnt[k]}, {8'h00, per_act[k]},
                                 dir[k] == fcp_pkg::FCP_DOWN, center_align_sel);
    end

    // Joined: the low channel's clock, gated by the high channel's enable.
    assign tick16 = en[0] && (clock_sel_polarity_reg[`FCP_SEL_LSB + L]
                              ? scaled_tick[p] : base_tick[p]);
    assign cnt16  = {cnt[0], cnt[1]};
    assign per16  = {per_act[0], per_act[1]};
    assign dty16  = {dty_act[0], dty_act[1]};
    assign step16 = fcp_step(cnt16, per16, dir[0] == fcp_pkg::FCP_DOWN, center_align_sel);

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        for (int k = 0; k < 2; k++) begin
          cnt[k]     <= 8'h00;
          per_act[k] <= `FCP_RST_PER;
          dty_act[k] <= `FCP_RST_DTY;
          dir[k]     <= fcp_pkg::FCP_UP;
        end
        lvl <= 2'b00;
      end else begin
        if (join_on) begin
          if (tick16) begin
            {cnt[0], cnt[1]} <= step16[15:0];
            dir[0] <= step16[16] ? fcp_pkg::FCP_DOWN : fcp_pkg::FCP_UP;
            if (step16[17]) begin
              for (int k = 0; k < 2; k++) begin
                per_act[k] <= per_buf[H + k];
                dty_act[k] <= dty_buf[H + k];
              end
            end
          end
          lvl[0] <= fcp_level(cnt16, dty16, clock_sel_polarity_reg[`FCP_POL_LSB + H],
                              center_align_sel);
          lvl[1] <= 1'b0;
        end else begin
          for (int k = 0; k < 2; k++) begin
            if (tick[k]) begin
              cnt[k] <= step8[k][7:0];
              dir[k] <= step8[k][16] ? fcp_pkg::FCP_DOWN : fcp_pkg::FCP_UP;
              if (step8[k][17]) begin
                per_act[k] <= per_buf[H + k];
                dty_act[k] <= dty_buf[H + k];
              end
            end
            lvl[k] <= fcp_level({8'h00, cnt[k]}, {8'h00, dty_act[k]},
                                clock_sel_polarity_reg[`FCP_POL_LSB + H + k],
                                center_align_sel);
          end
        end
        // A disabled channel's latches track the buffer, taking a write at once.
        for (int k = 0; k < 2; k++) begin
          if (!en[join_on ? 0 : k]) begin
            per_act[k] <= (wr_en && addr == 8'(`FCP_ADDR_PER0 + H + k))
                          ? wr_data : per_buf[H + k];
            dty_act[k] <= (wr_en && addr == 8'(`FCP_ADDR_DTY0 + H + k))
                          ? wr_data : dty_buf[H + k];
          end
        end
        // Counter write wins over counting; joined, either byte clears both.
        for (int k = 0; k < 2; k++) begin
          if (wr_en && (addr == 8'(`FCP_ADDR_CNT0 + H + k))) begin
            for (int j = 0; j < 2; j++) begin
              if (join_on || j == k) begin
                cnt[j]     <= 8'h00;
                dir[j]     <= fcp_pkg::FCP_UP;
                per_act[j] <= per_buf[H + j];
                dty_act[j] <= dty_buf[H + j];
              end
            end
          end
        end
      end
    end

    assign cnt_all[H]   = cnt[0];
    assign cnt_all[L]   = cnt[1];
    assign wave[H]      = lvl[0];
    assign wave[L]      = lvl[1];
    assign pwm_drive[H] = en[0];
    assign pwm_drive[L] = en[1] && !join_on;
  end

  // ==========================================================================
  // Port pins
  // ==========================================================================
  // The direction bit is never changed by an enable, only overridden.
  assign port_out  = (pwm_drive & wave) | (~pwm_drive & port_data);
  assign port_oe_n = ~(pwm_drive | port_dir);

  // ==========================================================================
  // Read back
  // ==========================================================================
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr)
      `FCP_ADDR_CLK:   rd_mux = clock_join_reg;
      `FCP_ADDR_POL:   rd_mux = clock_sel_polarity_reg;
      `FCP_ADDR_EN:    rd_mux = {4'h0, channel_enable_bits};
      `FCP_ADDR_PRES:  rd_mux = {1'b0, pres};
      `FCP_ADDR_SCAL0: rd_mux = scale_value_0;
      `FCP_ADDR_SCNT0: rd_mux = scnt0;
      `FCP_ADDR_SCAL1: rd_mux = scale_value_1;
      `FCP_ADDR_SCNT1: rd_mux = scnt1;
      `FCP_ADDR_CTL:   rd_mux = {7'h00, center_align_sel};
      `FCP_ADDR_PDAT:  rd_mux = {4'h0, (port_dir & port_data) | (~port_dir & port_in)};
      `FCP_ADDR_PDIR:  rd_mux = {4'h0, port_dir};
      default:         rd_mux = 8'h00;
    endcase
    for (int k = 0; k < 4; k++) begin
      if (addr == 8'(`FCP_ADDR_CNT0 + k)) begin
        rd_mux = cnt_all[k];
      end
      if (addr == 8'(`FCP_ADDR_PER0 + k)) begin
        rd_mux = per_buf[k];
      end
      if (addr == 8'(`FCP_ADDR_DTY0 + k)) begin
        rd_mux = dty_buf[k];
      end
    end
  end

  // Read data stand only in the cycle after the strobe; zero otherwise.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_en ? rd_mux : 8'h00;
    end
  end

endmodule // fcp_top

//--- src/fcp_params.svh
// Register offsets, field positions, reset values and widths of the four-channel PWM.
`ifndef FCP_PARAMS_SVH
`define FCP_PARAMS_SVH

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define FCP_ADDR_CLK      8'h40
`define FCP_ADDR_POL      8'h41
`define FCP_ADDR_EN       8'h42
`define FCP_ADDR_PRES     8'h43
`define FCP_ADDR_SCAL0    8'h44
`define FCP_ADDR_SCNT0    8'h45
`define FCP_ADDR_SCAL1    8'h46
`define FCP_ADDR_SCNT1    8'h47
`define FCP_ADDR_CNT0     8'h48
`define FCP_ADDR_PER0     8'h4C
`define FCP_ADDR_DTY0     8'h50
`define FCP_ADDR_CTL      8'h54
`define FCP_ADDR_PDAT     8'h56
`define FCP_ADDR_PDIR     8'h57

// ==========================================================================
// Field positions
// ==========================================================================
`define FCP_JOIN_HI_BIT   7
`define FCP_JOIN_LO_BIT   6
`define FCP_PCKA_LSB      3
`define FCP_PCKB_LSB      0
`define FCP_SEL_LSB       4
`define FCP_POL_LSB       0
`define FCP_CENTER_BIT    0

// ==========================================================================
// Reset values and widths
// ==========================================================================
`define FCP_RST_ZERO      8'h00
`define FCP_RST_PER       8'hFF
`define FCP_RST_DTY       8'hFF
`define FCP_PRES_W        7

`endif

//--- src/fcp_pkg.sv
// Shared types of the four-channel PWM.
package fcp_pkg;

  // Count direction of a center-aligned counter.
  typedef enum logic [1:0] {
    FCP_UP   = 2'b01,
    FCP_DOWN = 2'b10
  } fcp_dir_e;

endpackage

//--- src/fcp_scaler.sv
// Scaled clock divider: divides an input tick by (scale + 1) and then by two.
`timescale 1ns/10ps
module fcp_scaler (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       tick_in,
  input  wire logic       load,
  input  wire logic [7:0] scale,
  output logic            tick_out,
  output logic [7:0]      count
);

  logic half;

  // A tick leaves on every second underflow, which gives the final halving.
  assign tick_out = tick_in && (count == 8'h00) && half;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= 8'h00;
      half  <= 1'b0;
    end else if (load) begin
      count <= scale;
      half  <= 1'b0;
    end else if (tick_in) begin
      if (count == 8'h00) begin
        count <= scale;
        half  <= ~half;
      end else begin
        count <= count - 8'h01;
      end
    end
  end

endmodule // fcp_scaler

//--- src/fcp_clkgen.sv
// Prescaler that derives clock A and clock B enables from the module clock.
`timescale 1ns/10ps
`include "fcp_params.svh"
module fcp_clkgen (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   run,
  input  wire logic [2:0]             code_a,
  input  wire logic [2:0]             code_b,
  output logic                        tick_a,
  output logic                        tick_b,
  output logic [`FCP_PRES_W-1:0]      pres
);

  logic [`FCP_PRES_W-1:0] mask_a;
  logic [`FCP_PRES_W-1:0] mask_b;

  // Divide by two to the code: the tick fires when the low code bits are all ones.
  assign mask_a = `FCP_PRES_W'((8'h01 << code_a) - 8'h01);
  assign mask_b = `FCP_PRES_W'((8'h01 << code_b) - 8'h01);
  assign tick_a = run && ((pres & mask_a) == mask_a);
  assign tick_b = run && ((pres & mask_b) == mask_b);

  // The counter stops while no channel is enabled, to save power.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pres <= '0;
    end else if (run) begin
      pres <= pres + `FCP_PRES_W'(1);
    end
  end

endmodule // fcp_clkgen

//--- verif/fcp_top_sva.sv
// Assertion checker on the register port and pin outputs of the four-channel PWM.
`timescale 1ns/10ps
module fcp_top_sva (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] port_in,
  input wire logic [3:0] port_out,
  input wire logic [3:0] port_oe_n
);
  // ==========================================================================
  // Shadow copies of the registers that are read back or decide pin ownership
  // ==========================================================================
  logic [7:0] clk_sh;
  logic [7:0] pol_sh;
  logic [7:0] sc0_sh;
  logic [3:0] en_sh;
  logic [3:0] dir_sh;
  logic [3:0] drive_exp;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_sh <= 8'h00;
      pol_sh <= 8'h00;
      sc0_sh <= 8'h00;
      en_sh  <= 4'h0;
      dir_sh <= 4'h0;
    end else if (wr_en) begin
      case (addr)
        8'h40: clk_sh <= wr_data;
        8'h41: pol_sh <= wr_data;
        8'h42: en_sh <= wr_data[3:0];
        8'h44: sc0_sh <= wr_data;
        8'h57: dir_sh <= wr_data[3:0];
        default: ;
      endcase
    end
  end

  // A joined pair gives up the low channel's pin, so its enable no longer drives it.
  assign drive_exp = dir_sh | (en_sh & {~clk_sh[7], 1'b1, ~clk_sh[6], 1'b1});

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence rd_of(logic [7:0] a);
    rd_en && addr == a;
  endsequence

  property readback(logic [7:0] a, logic [7:0] v);
    rd_of(a) |=> rd_data == $past(v);
  endproperty

  read_idle_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not zero outside a read");
  clk_readback_a: assert property (readback(8'h40, clk_sh))
    else $error("clock and join register read back wrong");
  pol_readback_a: assert property (readback(8'h41, pol_sh))
    else $error("select and polarity register read back wrong");
  scale_readback_a: assert property (readback(8'h44, sc0_sh))
    else $error("scale register read back wrong");
  enable_readback_a: assert property (readback(8'h42, {4'h0, en_sh}))
    else $error("enable register read back wrong");
  pins_owned_a: assert property (port_oe_n == ~drive_exp)
    else $error("pin output enable does not follow enable and direction");
  join_lo_free_a: assert property (clk_sh[6] && !dir_sh[1] |-> port_oe_n[1])
    else $error("low pin of joined pair 0 and 1 still driven");
  join_hi_free_a: assert property (clk_sh[7] && !dir_sh[3] |-> port_oe_n[3])
    else $error("low pin of joined pair 2 and 3 still driven");
  reset_idle_a: assert property ($rose(rst_n) |-> port_oe_n == 4'hF && port_out == 4'h0)
    else $error("pins not released after reset");
endmodule // fcp_top_sva

bind fcp_top fcp_top_sva fcp_top_sva_i (.core_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en,
  .rd_data, .port_in, .port_out, .port_oe_n);

//--- verif/fcp_pin_load.sv
// Model of the external loads and sources on the four shared port pins.
`timescale 1ns/10ps
module fcp_pin_load (
  input  wire logic [3:0] port_out,
  input  wire logic [3:0] port_oe_n,
  input  wire logic [3:0] ext_level,
  output logic      [3:0] port_in
);
  // A driven pin reads back its own level; a released pin shows the outside source.
  always_comb port_in = (port_oe_n & ext_level) | (~port_oe_n & port_out);
endmodule // fcp_pin_load

//--- verif/fcp_top_test.sv
// Self-checking testbench of the four-channel PWM.
`timescale 1ns/10ps
module fcp_top_test;
  logic       core_clk;
  logic       rst_n;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] seen;
  logic [7:0] held;
  logic [3:0] port_in;
  logic [3:0] port_out;
  logic [3:0] port_oe_n;
  logic [3:0] ext_level;
  int         n_fail;
  int         total_checks;

  fcp_top fcp_top_i (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .port_in(port_in),
    .port_out(port_out), .port_oe_n(port_oe_n));
  fcp_pin_load fcp_pin_load_i (.port_out(port_out), .port_oe_n(port_oe_n),
    .ext_level(ext_level), .port_in(port_in));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Bus and compare tasks
  // ==========================================================================
  task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rd_chk(string name, logic [7:0] a, logic [7:0] exp);
    rd(a, seen);
    chk(name, seen, exp);
  endtask

  // Period and duty go in first, then the counter write restarts the channel cleanly.
  task automatic setup(logic [1:0] ch, logic [7:0] per, logic [7:0] duty);
    wr(8'h4C + ch, per);
    wr(8'h50 + ch, duty);
    wr(8'h48 + ch, 8'h00);
  endtask

  // The window must span whole periods so the high count does not depend on phase.
  task automatic wave(int ch, int n, int exp);
    int highs = 0;
    repeat (12) @(posedge core_clk);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (port_out[ch] === 1'b1) highs++;
    end
    chk("pin_drive", {7'h00, port_oe_n[ch]}, 8'h00);
    chk("high_cycles", highs[7:0], exp[7:0]);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    ext_level = 4'hA;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      rd_chk("reset_value", 8'h40 + i[7:0], (i >= 12) ? 8'hFF : 8'h00);
    end
    rd_chk("unmapped", 8'h60, 8'h00);
    wr(8'h45, 8'h77);
    rd_chk("read_only", 8'h45, 8'h00);
    wr(8'h40, 8'hA5);
    rd_chk("clock_join_reg", 8'h40, 8'hA5);
    wr(8'h41, 8'h5A);
    rd_chk("clock_sel_polarity_reg", 8'h41, 8'h5A);
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h00);
    wr(8'h57, 8'h08);
    wr(8'h56, 8'h08);
    rd(8'h56, seen);
    chk("port_read", seen & 8'h0F, 8'h0A);
    chk("gpio_oe_n", {4'h0, port_oe_n}, 8'h07);
    chk("gpio_out", {7'h00, port_out[3]}, 8'h01);
    wr(8'h57, 8'h00);
    setup(2'd0, 8'h03, 8'h01);
    wr(8'h42, 8'h01);
    wave(0, 16, 12);
    wr(8'h42, 8'h00);
    wr(8'h50, 8'h00);
    wr(8'h42, 8'h01);
    wave(0, 16, 16);
    wr(8'h50, 8'h04);
    wave(0, 16, 0);
    wr(8'h41, 8'h01);
    wr(8'h50, 8'h01);
    wave(0, 16, 4);
    wr(8'h54, 8'h01);
    wr(8'h50, 8'h02);
    wave(0, 24, 12);
    wr(8'h41, 8'h00);
    wave(0, 24, 12);
    wr(8'h54, 8'h00);
    wr(8'h42, 8'h00);
    wr(8'h40, 8'h10);
    setup(2'd0, 8'h03, 8'h01);
    wr(8'h42, 8'h01);
    wave(0, 32, 24);
    wr(8'h42, 8'h00);
    wr(8'h40, 8'h01);
    setup(2'd2, 8'h03, 8'h01);
    wr(8'h42, 8'h04);
    wave(2, 32, 24);
    wr(8'h42, 8'h00);
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h10);
    wr(8'h44, 8'h01);
    setup(2'd0, 8'h01, 8'h01);
    wr(8'h42, 8'h01);
    wave(0, 32, 16);
    wr(8'h42, 8'h00);
    wr(8'h41, 8'h80);
    wr(8'h46, 8'h00);
    setup(2'd3, 8'h01, 8'h01);
    wr(8'h42, 8'h08);
    wave(3, 16, 8);
    wr(8'h42, 8'h00);
    wr(8'h41, 8'h10);
    wr(8'h44, 8'hFF);
    setup(2'd0, 8'h03, 8'h01);
    wr(8'h42, 8'h01);
    repeat (20) @(posedge core_clk);
    chk("slow_start", {7'h00, port_out[0]}, 8'h00);
    wr(8'h50, 8'h00);
    repeat (20) @(posedge core_clk);
    chk("duty_buffered", {7'h00, port_out[0]}, 8'h00);
    rd_chk("channel_counter", 8'h48, 8'h00);
    wr(8'h48, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("counter_load", {7'h00, port_out[0]}, 8'h01);
    wr(8'h42, 8'h00);
    wr(8'h41, 8'h00);
    wr(8'h40, 8'h40);
    setup(2'd0, 8'h00, 8'h00);
    setup(2'd1, 8'h03, 8'h01);
    wr(8'h42, 8'h03);
    wave(0, 16, 12);
    chk("join_lo_pin", {7'h00, port_oe_n[1]}, 8'h01);
    wr(8'h42, 8'h00);
    setup(2'd0, 8'h01, 8'h01);
    setup(2'd1, 8'h01, 8'h00);
    wr(8'h42, 8'h01);
    wave(0, 516, 4);
    wr(8'h42, 8'h00);
    wr(8'h40, 8'h80);
    setup(2'd2, 8'h00, 8'h00);
    setup(2'd3, 8'h03, 8'h01);
    wr(8'h42, 8'h04);
    wave(2, 16, 12);
    chk("join_hi_pin", {7'h00, port_oe_n[3]}, 8'h01);
    wr(8'h42, 8'h00);
    rd(8'h4B, held);
    repeat (10) @(posedge core_clk);
    rd_chk("counter_hold", 8'h4B, held);
    give_verdict();
  end
endmodule // fcp_top_test
